// file: hw/cfg_ctrl_pkg.sv
// Package: constants for the configuration control block.
// Assumes a 125 MHz system clock and a JTAG link sampled by it.
package cfg_ctrl_pkg;
  // Instruction register width and codes
  localparam int IR_WIDTH = 10;
  localparam logic [9:0] IR_BYPASS = 10'h3FF;
  localparam logic [9:0] IR_IDCODE = 10'h006;
  localparam logic [9:0] IR_SAMPLE = 10'h005;
  localparam logic [9:0] IR_PROGRAM = 10'h002;
  localparam logic [9:0] IR_CHECK_DONE = 10'h004;
  localparam logic [9:0] IR_IO_SETUP = 10'h00D;
  localparam logic [9:0] IR_RECONFIG_PULSE = 10'h001;
  localparam logic [9:0] IR_EXTEST = 10'h00F;
  // Instruction register capture pattern
  localparam logic [9:0] IR_CAPTURE = 10'h001;
  // Identity code, value arbitrary
  localparam logic [31:0] ID_CODE = 32'h1234_5001;
  // Configuration image size in bits (shortened default)
  localparam int IMAGE_BITS = 64;
  // Initialization cycles after the last data bit
  localparam int INIT_TCK_CYCLES = 1222;
  // Serial data word width and FIFO depth
  localparam int WORD_W = 8;
  localparam int FIFO_DEPTH = 4;
  // TAP controller states
  typedef enum logic [3:0] {
    TAP_RESET = 4'h0, TAP_IDLE = 4'h1, TAP_SEL_DR = 4'h2, TAP_CAP_DR = 4'h3,
    TAP_SH_DR = 4'h4, TAP_EX1_DR = 4'h5, TAP_PA_DR = 4'h6, TAP_EX2_DR = 4'h7,
    TAP_UP_DR = 4'h8, TAP_SEL_IR = 4'h9, TAP_CAP_IR = 4'hA, TAP_SH_IR = 4'hB,
    TAP_EX1_IR = 4'hC, TAP_PA_IR = 4'hD, TAP_EX2_IR = 4'hE, TAP_UP_IR = 4'hF
  } tap_state_t;
  // Configuration states
  typedef enum logic [2:0] {
    CFG_WAIT = 3'h0, CFG_SERIAL = 3'h1, CFG_JTAG = 3'h2, CFG_INIT = 3'h3,
    CFG_USER = 3'h4, CFG_ERROR = 3'h5, CFG_IO_SETUP = 3'h6
  } cfg_state_t;
endpackage

// file: hw/edge_sync.sv
// Three-stage synchroniser with agreement filter for an outside pin.
// Assumes the pin is asynchronous to i_clk_sys.
`timescale 1ns/1ns
module edge_sync
(
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_pin,
  output logic o_level,
  output logic o_rise,
  output logic o_fall
);
  logic s1_reg; // First stage, read only by the second
  logic s2_reg;
  logic s3_reg;
  // Shift chain and filtered level
  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
    begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
      o_level <= 1'b0;
    end
    else
    begin
      s1_reg <= i_pin;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg)
        o_level <= s3_reg;
    end
  end
  // Edge pulses when the filtered level is about to change
  assign o_rise = (s2_reg == s3_reg) && s3_reg && !o_level;
  assign o_fall = (s2_reg == s3_reg) && !s3_reg && o_level;
endmodule

// file: hw/word_fifo.sv
// Small synchronous FIFO with valid/ready on both sides.
// Assumes a single clock domain.
`timescale 1ns/1ns
module word_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
)
(
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_flush,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH]; // Storage words
  logic [AW-1:0] wr_reg; // Write pointer
  logic [AW-1:0] rd_reg; // Read pointer
  logic [AW:0] cnt_reg; // Fill count
  logic push;
  logic pop;
  assign o_in_ready = (cnt_reg != (AW+1)'(DEPTH));
  assign o_out_valid = (cnt_reg != '0);
  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;
  assign o_out_data = mem[rd_reg];
  // Storage write
  always_ff @(posedge i_clk_sys)
  begin
    if (push)
      mem[wr_reg] <= i_in_data;
  end
  // Pointers and count
  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst || i_flush)
    begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
    end
    else
    begin
      if (push)
        wr_reg <= (wr_reg == AW'(DEPTH-1)) ? '0 : wr_reg + 1'b1;
      if (pop)
        rd_reg <= (rd_reg == AW'(DEPTH-1)) ? '0 : rd_reg + 1'b1;
      cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// file: hw/cfg_ctrl.sv
// Configuration control: serial chain load, JTAG TAP and configuration path.
// Assumes TCK and the serial load clock are slow pins sampled by i_clk_sys.
// Notes on behaviour
// R1: Finished device drives chain enable output low
// R2: Serial clock, data, request, status, complete shared
// R3: Shared lines make whole chain enter user together
// R4: Error pulls status low; host reconfigures chain
// R5: JTAG load preempts serial load immediately
// R6: User I/O tri-stated during JTAG configuration
// R7: No decompression or decryption on JTAG data
// R8: Bypass passes TDI to TDO, one TCK later
// R9: Configuration complete readable over JTAG
// R10: Host gives 1222 TCK cycles for initialization
// R11: Device clear and output enable ignored by JTAG
// R12: Host holds chip enable low for JTAG
// R13: I/O-setup instruction interrupts configuration
// R14: Reconfigure after I/O-setup via JTAG, pin or pulse
// R15: Other instructions only after I/O-setup
// R16: Host orders JTAG chain like config chain
// R17: JTAG-only systems keep status lines separate
// R18: Complete held low until data loaded, initialization
// R19: TDI on TCK rise, TDO on fall, else tri-state
// R20: Standard TAP controller; IR selects data path
`timescale 1ns/1ns
module cfg_ctrl
(
  input wire logic i_clk_sys,
  input wire logic i_rst,
  // JTAG link
  input wire logic i_tck,
  input wire logic i_tms,
  input wire logic i_tdi,
  output logic o_tdo,
  output logic o_tdo_oe,
  // Serial chain link
  input wire logic i_serial_load_clock,
  input wire logic i_serial_load_data,
  input wire logic i_config_request_n,
  input wire logic i_chip_enable_n,
  output logic o_chain_enable_n,
  input wire logic i_config_status_n,
  output logic o_config_status_n_oe,
  input wire logic i_config_complete,
  output logic o_config_complete_oe,
  // Device-wide controls and user pins
  input wire logic i_device_wide_clear_n,
  input wire logic i_device_wide_output_enable,
  input wire logic i_frame_error,
  output logic o_user_io_oe_allow,
  output logic o_user_clear_n,
  output logic o_user_mode,
  // Configuration word stream to the memory array
  output logic o_cfg_valid,
  input wire logic i_cfg_ready,
  output logic [cfg_ctrl_pkg::WORD_W-1:0] o_cfg_data,
  output logic o_cfg_from_jtag,
  output logic o_cfg_decode_en
);
  // Synchronised pins
  logic tck_lvl, tck_rise, tck_fall;
  logic tms_lvl, tdi_lvl, serial_load_clock_rise, data_lvl;
  logic req_lvl, req_fall, ce_lvl, st_lvl, cd_lvl;
  logic unused_a, unused_b, unused_c, unused_d, unused_e, unused_f, unused_g;
  logic unused_h, unused_i, unused_j, unused_k, unused_l;
  edge_sync u_tck (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_pin(i_tck),
    .o_level(tck_lvl), .o_rise(tck_rise), .o_fall(tck_fall));
  edge_sync u_tms (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_pin(i_tms),
    .o_level(tms_lvl), .o_rise(unused_a), .o_fall(unused_b));
  edge_sync u_tdi (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_pin(i_tdi),
    .o_level(tdi_lvl), .o_rise(unused_c), .o_fall(unused_d));
  edge_sync u_serial_load_clock (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_pin(i_serial_load_clock),
    .o_level(unused_e), .o_rise(serial_load_clock_rise), .o_fall(unused_f));
  edge_sync u_data (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_pin(i_serial_load_data),
    .o_level(data_lvl), .o_rise(unused_g), .o_fall(unused_h));
  edge_sync u_req (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_pin(i_config_request_n),
    .o_level(req_lvl), .o_rise(unused_i), .o_fall(req_fall));
  edge_sync u_ce (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_pin(i_chip_enable_n),
    .o_level(ce_lvl), .o_rise(unused_j), .o_fall(unused_k));
  edge_sync u_st (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_pin(i_config_status_n),
    .o_level(st_lvl), .o_rise(unused_l), .o_fall());
  edge_sync u_cd (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_pin(i_config_complete),
    .o_level(cd_lvl), .o_rise(), .o_fall());

  // TAP controller
  cfg_ctrl_pkg::tap_state_t tap_reg, tap_next;
  // Next TAP state from TMS, standard graph
  always_comb
  begin
    case (tap_reg)
      cfg_ctrl_pkg::TAP_RESET: tap_next = tms_lvl ? cfg_ctrl_pkg::TAP_RESET : cfg_ctrl_pkg::TAP_IDLE;
      cfg_ctrl_pkg::TAP_IDLE: tap_next = tms_lvl ? cfg_ctrl_pkg::TAP_SEL_DR : cfg_ctrl_pkg::TAP_IDLE;
      cfg_ctrl_pkg::TAP_SEL_DR: tap_next = tms_lvl ? cfg_ctrl_pkg::TAP_SEL_IR : cfg_ctrl_pkg::TAP_CAP_DR;
      cfg_ctrl_pkg::TAP_CAP_DR: tap_next = tms_lvl ? cfg_ctrl_pkg::TAP_EX1_DR : cfg_ctrl_pkg::TAP_SH_DR;
      cfg_ctrl_pkg::TAP_SH_DR: tap_next = tms_lvl ? cfg_ctrl_pkg::TAP_EX1_DR : cfg_ctrl_pkg::TAP_SH_DR;
      cfg_ctrl_pkg::TAP_EX1_DR: tap_next = tms_lvl ? cfg_ctrl_pkg::TAP_UP_DR : cfg_ctrl_pkg::TAP_PA_DR;
      cfg_ctrl_pkg::TAP_PA_DR: tap_next = tms_lvl ? cfg_ctrl_pkg::TAP_EX2_DR : cfg_ctrl_pkg::TAP_PA_DR;
      cfg_ctrl_pkg::TAP_EX2_DR: tap_next = tms_lvl ? cfg_ctrl_pkg::TAP_UP_DR : cfg_ctrl_pkg::TAP_SH_DR;
      cfg_ctrl_pkg::TAP_UP_DR: tap_next = tms_lvl ? cfg_ctrl_pkg::TAP_SEL_DR : cfg_ctrl_pkg::TAP_IDLE;
      cfg_ctrl_pkg::TAP_SEL_IR: tap_next = tms_lvl ? cfg_ctrl_pkg::TAP_RESET : cfg_ctrl_pkg::TAP_CAP_IR;
      cfg_ctrl_pkg::TAP_CAP_IR: tap_next = tms_lvl ? cfg_ctrl_pkg::TAP_EX1_IR : cfg_ctrl_pkg::TAP_SH_IR;
      cfg_ctrl_pkg::TAP_SH_IR: tap_next = tms_lvl ? cfg_ctrl_pkg::TAP_EX1_IR : cfg_ctrl_pkg::TAP_SH_IR;
      cfg_ctrl_pkg::TAP_EX1_IR: tap_next = tms_lvl ? cfg_ctrl_pkg::TAP_UP_IR : cfg_ctrl_pkg::TAP_PA_IR;
      cfg_ctrl_pkg::TAP_PA_IR: tap_next = tms_lvl ? cfg_ctrl_pkg::TAP_EX2_IR : cfg_ctrl_pkg::TAP_PA_IR;
      cfg_ctrl_pkg::TAP_EX2_IR: tap_next = tms_lvl ? cfg_ctrl_pkg::TAP_UP_IR : cfg_ctrl_pkg::TAP_SH_IR;
      cfg_ctrl_pkg::TAP_UP_IR: tap_next = tms_lvl ? cfg_ctrl_pkg::TAP_SEL_DR : cfg_ctrl_pkg::TAP_IDLE;
      default: tap_next = cfg_ctrl_pkg::TAP_RESET;
    endcase
  end
  // State advances on each sampled TCK rise; clear pins have no say here
  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
      tap_reg <= cfg_ctrl_pkg::TAP_RESET;
    else if (tck_rise)
      tap_reg <= tap_next; // R20 R11
  end

  // Instruction handling
  logic [9:0] ir_sh_reg; // IR shift stage
  logic [9:0] ir_reg; // Active instruction
  logic io_setup_done_reg; // I/O-setup has interrupted configuration
  logic ir_allowed;
  // Only the free instructions work until I/O-setup has run
  assign ir_allowed = io_setup_done_reg || ir_sh_reg == cfg_ctrl_pkg::IR_BYPASS
    || ir_sh_reg == cfg_ctrl_pkg::IR_IDCODE || ir_sh_reg == cfg_ctrl_pkg::IR_SAMPLE
    || ir_sh_reg == cfg_ctrl_pkg::IR_IO_SETUP || ir_sh_reg == cfg_ctrl_pkg::IR_PROGRAM
    || ir_sh_reg == cfg_ctrl_pkg::IR_CHECK_DONE || ir_sh_reg == cfg_ctrl_pkg::IR_RECONFIG_PULSE;
  // IR capture, shift and update
  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
    begin
      ir_sh_reg <= '0;
      ir_reg <= cfg_ctrl_pkg::IR_IDCODE;
    end
    else if (tck_rise)
    begin
      if (tap_reg == cfg_ctrl_pkg::TAP_RESET)
        ir_reg <= cfg_ctrl_pkg::IR_IDCODE;
      else if (tap_reg == cfg_ctrl_pkg::TAP_CAP_IR)
        ir_sh_reg <= cfg_ctrl_pkg::IR_CAPTURE;
      else if (tap_reg == cfg_ctrl_pkg::TAP_SH_IR)
        ir_sh_reg <= {tdi_lvl, ir_sh_reg[9:1]}; // R19
      else if (tap_reg == cfg_ctrl_pkg::TAP_UP_IR)
        ir_reg <= ir_allowed ? ir_sh_reg : cfg_ctrl_pkg::IR_BYPASS; // R15
    end
  end

  // Data registers
  logic bypass_reg; // Single bypass bit
  logic [31:0] dr_reg; // Identity / status shift
  logic [2:0] bit_cnt_reg; // Bits gathered into a word
  logic [7:0] word_reg; // Word being gathered
  logic word_valid; // Word ready for the FIFO
  logic fifo_ready;
  logic is_bypass;
  assign is_bypass = ir_reg == cfg_ctrl_pkg::IR_BYPASS;
  // Bypass and capture/shift of the selected path
  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
    begin
      bypass_reg <= 1'b0;
      dr_reg <= '0;
    end
    else if (tck_rise)
    begin
      if (tap_reg == cfg_ctrl_pkg::TAP_CAP_DR)
      begin
        bypass_reg <= 1'b0;
        if (ir_reg == cfg_ctrl_pkg::IR_IDCODE)
          dr_reg <= cfg_ctrl_pkg::ID_CODE;
        else
          dr_reg <= {31'h0, cd_lvl}; // R9
      end
      else if (tap_reg == cfg_ctrl_pkg::TAP_SH_DR)
      begin
        bypass_reg <= tdi_lvl; // R8
        dr_reg <= {tdi_lvl, dr_reg[31:1]};
      end
    end
  end

  // TDO update on falling TCK, driven only while shifting
  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
    begin
      o_tdo <= 1'b0;
      o_tdo_oe <= 1'b0;
    end
    else if (tck_fall)
    begin
      o_tdo_oe <= tap_reg == cfg_ctrl_pkg::TAP_SH_DR || tap_reg == cfg_ctrl_pkg::TAP_SH_IR; // R19
      if (tap_reg == cfg_ctrl_pkg::TAP_SH_IR)
        o_tdo <= ir_sh_reg[0];
      else if (is_bypass)
        o_tdo <= bypass_reg; // R8
      else
        o_tdo <= dr_reg[0];
    end
  end

  // Configuration sequencer
  cfg_ctrl_pkg::cfg_state_t cfg_reg;
  logic [15:0] bits_reg; // Image bits taken
  logic [10:0] init_reg; // Initialization TCK count
  logic jtag_prog; // JTAG programming shift
  logic serial_bit;
  logic take_bit;
  logic take_data;
  assign jtag_prog = tck_rise && tap_reg == cfg_ctrl_pkg::TAP_SH_DR
    && ir_reg == cfg_ctrl_pkg::IR_PROGRAM;
  assign serial_bit = serial_load_clock_rise && cfg_reg == cfg_ctrl_pkg::CFG_SERIAL && fifo_ready;
  assign take_bit = serial_bit || (cfg_reg == cfg_ctrl_pkg::CFG_JTAG && jtag_prog);
  assign take_data = serial_bit ? data_lvl : tdi_lvl;
  // Main sequence
  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
    begin
      cfg_reg <= cfg_ctrl_pkg::CFG_WAIT;
      bits_reg <= '0;
      init_reg <= '0;
    end
    else if (!req_lvl || (req_fall) ||
      (tck_rise && tap_reg == cfg_ctrl_pkg::TAP_UP_IR
       && ir_sh_reg == cfg_ctrl_pkg::IR_RECONFIG_PULSE && ir_allowed))
    begin
      cfg_reg <= cfg_ctrl_pkg::CFG_WAIT; // R14
      bits_reg <= '0;
      init_reg <= '0;
    end
    else if (tck_rise && tap_reg == cfg_ctrl_pkg::TAP_UP_IR
      && ir_sh_reg == cfg_ctrl_pkg::IR_IO_SETUP)
      cfg_reg <= cfg_ctrl_pkg::CFG_IO_SETUP; // R13
    else if (tck_rise && tap_reg == cfg_ctrl_pkg::TAP_UP_IR
      && ir_sh_reg == cfg_ctrl_pkg::IR_PROGRAM && cfg_reg != cfg_ctrl_pkg::CFG_JTAG)
    begin
      cfg_reg <= cfg_ctrl_pkg::CFG_JTAG; // R5
      bits_reg <= '0;
    end
    else
    begin
      case (cfg_reg)
        cfg_ctrl_pkg::CFG_WAIT:
          if (!ce_lvl && st_lvl)
            cfg_reg <= cfg_ctrl_pkg::CFG_SERIAL;
        cfg_ctrl_pkg::CFG_SERIAL, cfg_ctrl_pkg::CFG_JTAG:
        begin
          if (i_frame_error)
            cfg_reg <= cfg_ctrl_pkg::CFG_ERROR; // R4
          else if (!st_lvl)
            cfg_reg <= cfg_ctrl_pkg::CFG_ERROR; // R4
          else if (take_bit)
          begin
            bits_reg <= bits_reg + 16'h0001;
            if (bits_reg == 16'(cfg_ctrl_pkg::IMAGE_BITS - 1))
            begin
              cfg_reg <= cfg_ctrl_pkg::CFG_INIT; // R18
              init_reg <= '0;
            end
          end
        end
        cfg_ctrl_pkg::CFG_INIT:
        begin
          if (!st_lvl)
            cfg_reg <= cfg_ctrl_pkg::CFG_ERROR;
          else if (cd_lvl && (serial_load_clock_rise || tck_rise))
          begin
            init_reg <= init_reg + 11'h001;
            if (init_reg == 11'(cfg_ctrl_pkg::INIT_TCK_CYCLES - 1) || serial_load_clock_rise)
              cfg_reg <= cfg_ctrl_pkg::CFG_USER; // R3 R10
          end
        end
        cfg_ctrl_pkg::CFG_ERROR:
          cfg_reg <= cfg_ctrl_pkg::CFG_ERROR;
        cfg_ctrl_pkg::CFG_USER:
          cfg_reg <= cfg_ctrl_pkg::CFG_USER;
        cfg_ctrl_pkg::CFG_IO_SETUP:
          cfg_reg <= cfg_ctrl_pkg::CFG_IO_SETUP;
        default:
          cfg_reg <= cfg_ctrl_pkg::CFG_WAIT;
      endcase
    end
  end

  // I/O-setup flag cleared by a fresh configuration request
  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst || !req_lvl)
      io_setup_done_reg <= 1'b0;
    else if (cfg_reg == cfg_ctrl_pkg::CFG_IO_SETUP)
      io_setup_done_reg <= 1'b1;
  end

  // Bit gathering into words
  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst || cfg_reg == cfg_ctrl_pkg::CFG_WAIT || (cfg_reg == cfg_ctrl_pkg::CFG_JTAG && !o_cfg_from_jtag))
    begin
      // First JTAG cycle drops any half-gathered serial word
      bit_cnt_reg <= '0; // R5
      word_reg <= '0;
    end
    else if (take_bit)
    begin
      word_reg <= {take_data, word_reg[7:1]};
      bit_cnt_reg <= bit_cnt_reg + 3'h1;
    end
  end
  assign word_valid = take_bit && bit_cnt_reg == 3'h7;

  // Word FIFO toward the memory array
  word_fifo #(.WIDTH(cfg_ctrl_pkg::WORD_W), .DEPTH(cfg_ctrl_pkg::FIFO_DEPTH)) u_fifo (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_flush(cfg_reg == cfg_ctrl_pkg::CFG_WAIT),
    .i_in_valid(word_valid),
    .o_in_ready(fifo_ready),
    .i_in_data({take_data, word_reg[7:1]}),
    .o_out_valid(o_cfg_valid),
    .i_out_ready(i_cfg_ready),
    .o_out_data(o_cfg_data)
  );

  // Path flags for the array: JTAG data is never decoded
  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
    begin
      o_cfg_from_jtag <= 1'b0;
      o_cfg_decode_en <= 1'b0;
    end
    else
    begin
      o_cfg_from_jtag <= cfg_reg == cfg_ctrl_pkg::CFG_JTAG;
      o_cfg_decode_en <= cfg_reg == cfg_ctrl_pkg::CFG_SERIAL; // R7
    end
  end

  // Shared-line drivers and user-side outputs
  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
    begin
      o_config_complete_oe <= 1'b1;
      o_config_status_n_oe <= 1'b1;
      o_chain_enable_n <= 1'b1;
      o_user_mode <= 1'b0;
      o_user_io_oe_allow <= 1'b0;
      o_user_clear_n <= 1'b0;
    end
    else
    begin
      o_config_complete_oe <= !(cfg_reg == cfg_ctrl_pkg::CFG_INIT
        || cfg_reg == cfg_ctrl_pkg::CFG_USER); // R18 R2
      o_config_status_n_oe <= cfg_reg == cfg_ctrl_pkg::CFG_ERROR || !req_lvl; // R4
      o_chain_enable_n <= !(cfg_reg == cfg_ctrl_pkg::CFG_INIT
        || cfg_reg == cfg_ctrl_pkg::CFG_USER); // R1
      o_user_mode <= cfg_reg == cfg_ctrl_pkg::CFG_USER;
      o_user_io_oe_allow <= cfg_reg == cfg_ctrl_pkg::CFG_USER
        && i_device_wide_output_enable; // R6
      o_user_clear_n <= cfg_reg == cfg_ctrl_pkg::CFG_USER && i_device_wide_clear_n;
    end
  end

  // Checks
  sequence jtag_cfg_s;
    cfg_reg == cfg_ctrl_pkg::CFG_JTAG;
  endsequence
  io_hiz_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    jtag_cfg_s |=> !o_user_io_oe_allow) else $error("user io driven in jtag load"); // R6
  no_decode_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    jtag_cfg_s |=> !o_cfg_decode_en) else $error("decode on jtag data"); // R7
  chain_en_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    cfg_reg == cfg_ctrl_pkg::CFG_USER |=> !o_chain_enable_n) else $error("chain enable"); // R1
  done_low_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    cfg_reg == cfg_ctrl_pkg::CFG_SERIAL |=> o_config_complete_oe) else $error("done"); // R18
  err_status_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    cfg_reg == cfg_ctrl_pkg::CFG_ERROR |=> o_config_status_n_oe) else $error("status"); // R4
  tdo_hiz_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    tck_fall && tap_reg == cfg_ctrl_pkg::TAP_IDLE |=> !o_tdo_oe) else $error("tdo oe"); // R19
  preempt_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    tck_rise && tap_reg == cfg_ctrl_pkg::TAP_UP_IR && ir_sh_reg == cfg_ctrl_pkg::IR_PROGRAM
    && req_lvl && !req_fall |=> cfg_reg == cfg_ctrl_pkg::CFG_JTAG) else $error("preempt"); // R5
  io_setup_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    tck_rise && tap_reg == cfg_ctrl_pkg::TAP_UP_IR && ir_sh_reg == cfg_ctrl_pkg::IR_IO_SETUP
    && req_lvl && !req_fall |=> cfg_reg == cfg_ctrl_pkg::CFG_IO_SETUP) else $error("io"); // R13
endmodule

// file: testbench/jtag_host.sv
// Host model for the JTAG pins and serial load pins of one device.
// Assumes i_clk_sys at 8 ns; link clocks stand still between transfers.
`timescale 1ns/1ns
module jtag_host
(
  input wire logic i_clk_sys,
  input wire logic i_tdo,
  output logic o_tck,
  output logic o_tms,
  output logic o_tdi,
  output logic o_serial_load_clock,
  output logic o_data
);
  // Idle levels; TDI and serial data rest at their pull-up level
  initial
  begin
    o_tck = 1'b0;
    o_tms = 1'b1;
    o_tdi = 1'b1;
    o_serial_load_clock = 1'b0;
    o_data = 1'b1;
  end
  // Half of the 80 ns link period, moved on falling edges
  task automatic half();
    repeat (5) @(negedge i_clk_sys);
  endtask
  // One TCK pulse: TMS and TDI set up before the rise, TDO read there
  task automatic tclk(input logic tms, input logic tdi, output logic tdo);
    o_tms = tms;
    o_tdi = tdi;
    half();
    tdo = i_tdo;
    o_tck = 1'b1;
    half();
    o_tck = 1'b0;
    o_tdi = 1'b1;
  endtask
  // TMS walk, LSB first, zeros past bit 7 (long Run-Test/Idle stays)
  task automatic walk(input int n, input logic [7:0] tms);
    logic t;
    for (int i = 0; i < n; i++) tclk((i < 8) ? tms[i] : 1'b0, 1'b1, t);
  endtask
  // Walk to a shift state, shift n bits LSB first, leave via Update to Idle
  task automatic scan(input int pre, input logic [7:0] ptms, input int n,
                      input logic [63:0] din, output logic [63:0] dout);
    dout = '0;
    walk(pre, ptms);
    for (int i = 0; i < n; i++) tclk(i == n - 1, din[i], dout[i]);
    walk(2, 8'h01);
  endtask
  // One serial load bit, data set up before the clock rise
  task automatic sbit(input logic d);
    o_data = d;
    half();
    o_serial_load_clock = 1'b1;
    half();
    o_serial_load_clock = 1'b0;
    o_data = 1'b1;
  endtask
endmodule

// file: testbench/tb_top.sv
// Self-checking bench for cfg_ctrl, host model on its link pins.
// Assumes the package constants; shared lines have pull-ups here.
`timescale 1ns/1ns
module tb_top;
  typedef struct {logic [9:0] ir; logic [31:0] din; logic [31:0] msk; logic [31:0] ex;} row_t;
  logic i_clk_sys, i_rst, tck, tms, tdi, tdo, tdo_oe, serial_load_clock, sdat, req_n, st_oe, done_oe;
  logic chain_n, clr_n, ferr, io_allow, cv, cr, fj, dec;
  logic [cfg_ctrl_pkg::WORD_W-1:0] cd;
  logic [63:0] img, v;
  logic [7:0] exp_q[$];
  wire logic st_n;
  wire logic done;
  int n_mismatch = 0;
  int total_checks = 0;
  int cyc = 0;
  row_t rows[3];
  // Open-drain shared lines, pulled up, kept per device
  assign st_n = ~st_oe;
  assign done = ~done_oe;
  // 125 MHz system clock
  initial
  begin
    i_clk_sys = 1'b0;
    forever #4 i_clk_sys = ~i_clk_sys;
  end
  // Chip enable tied low, device-wide output enable tied on
  cfg_ctrl dut
  (
    .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_tck(tck), .i_tms(tms), .i_tdi(tdi),
    .o_tdo(tdo), .o_tdo_oe(tdo_oe), .i_serial_load_clock(serial_load_clock), .i_serial_load_data(sdat),
    .i_config_request_n(req_n), .i_chip_enable_n(1'b0), .o_chain_enable_n(chain_n),
    .i_config_status_n(st_n), .o_config_status_n_oe(st_oe), .i_config_complete(done),
    .o_config_complete_oe(done_oe), .i_device_wide_clear_n(clr_n),
    .i_device_wide_output_enable(1'b1), .i_frame_error(ferr), .o_user_io_oe_allow(io_allow),
    .o_user_clear_n(), .o_user_mode(), .o_cfg_valid(cv), .i_cfg_ready(cr), .o_cfg_data(cd),
    .o_cfg_from_jtag(fj), .o_cfg_decode_en(dec)
  );
  jtag_host host
  (
    .i_clk_sys(i_clk_sys), .i_tdo(tdo), .o_tck(tck), .o_tms(tms), .o_tdi(tdi),
    .o_serial_load_clock(serial_load_clock), .o_data(sdat)
  );
  // Compare and count
  task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] ex);
    total_checks++;
    if (seen !== ex)
    begin
      $display("wrong value %s expected %0h seen %0h", nm, ex, seen);
      n_mismatch++;
    end
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(negedge i_clk_sys);
  endtask
  // Expected words of one image, low byte first
  task automatic ld();
    for (int i = 0; i < 8; i++) exp_q.push_back(img[i*8 +: 8]);
  endtask
  // Reconfiguration request pulse on the shared request line
  task automatic pulse_req();
    req_n = 1'b0;
    wait_n(10);
    req_n = 1'b1;
    wait_n(10);
  endtask
  // Word sink with run limit
  always @(posedge i_clk_sys)
  begin
    cyc <= cyc + 1;
    if (cv === 1'b1 && cr === 1'b1)
      chk("word", cd, (exp_q.size() > 0) ? exp_q.pop_front() : 8'hXX);
    if (cyc == 40000)
    begin
      n_mismatch++;
      test_done();
    end
  end
  // Main sequence
  initial
  begin
    i_rst = 1'b1;
    req_n = 1'b1;
    ferr = 1'b0;
    clr_n = 1'b1;
    cr = 1'b1;
    for (int i = 0; i < 8; i++) img[i*8 +: 8] = 8'h35 + 8'(i) * 8'h1D;
    rows = '{'{cfg_ctrl_pkg::IR_IDCODE, 32'h0, 32'hFFFFFFFF, cfg_ctrl_pkg::ID_CODE},
             '{cfg_ctrl_pkg::IR_BYPASS, 32'hA5, 32'hFFFFFFFF, 32'h14A},
             '{cfg_ctrl_pkg::IR_CHECK_DONE, 32'h0, 32'h1, 32'h0}};
    wait_n(20);
    i_rst = 1'b0;
    wait_n(6);
    chk("reset", {done_oe, chain_n, tdo_oe}, 3'b110);
    $display("test reset done");
    host.walk(6, 8'h1F);
    foreach (rows[i])
    begin
      host.scan(4, 8'h03, 10, {54'h0, rows[i].ir}, v);
      host.scan(3, 8'h01, 32, {32'h0, rows[i].din}, v);
      chk("dr", v[31:0] & rows[i].msk, rows[i].ex);
    end
    $display("test rows done");
    // Serial load with the sink stalled for three words
    cr = 1'b0;
    ld();
    for (int i = 0; i < 64; i++)
    begin
      cr = (i >= 24);
      host.sbit(img[i]);
    end
    wait_n(4);
    chk("serial", {done_oe, chain_n, dut.o_user_mode, fj, dec}, 5'b00000);
    host.sbit(1'b1);
    wait_n(4);
    chk("user", {dut.o_user_mode, 32'(exp_q.size())}, {1'b1, 32'h0});
    $display("test serial done");
    // Frame error mid-load pulls status low until a new request
    pulse_req();
    host.sbit(1'b0);
    ferr = 1'b1;
    wait_n(1);
    ferr = 1'b0;
    wait_n(2);
    chk("error", {st_oe, dut.o_user_mode}, 2'b10);
    pulse_req();
    chk("status", st_oe, 1'b0);
    $display("test error done");
    // JTAG load preempting a serial load in progress
    host.sbit(1'b1);
    ld();
    host.scan(4, 8'h03, 10, {54'h0, cfg_ctrl_pkg::IR_PROGRAM}, v);
    wait_n(4);
    chk("path", {fj, dec, io_allow}, 3'b100);
    clr_n = 1'b0;
    host.scan(3, 8'h01, cfg_ctrl_pkg::IMAGE_BITS, img, v);
    wait_n(4);
    chk("loaded", {done_oe, io_allow}, 2'b00);
    host.walk(1200, 8'h00);
    chk("init", dut.o_user_mode, 1'b0);
    host.walk(30, 8'h00);
    chk("init", dut.o_user_mode, 1'b1);
    host.scan(4, 8'h03, 10, {54'h0, cfg_ctrl_pkg::IR_CHECK_DONE}, v);
    host.scan(3, 8'h01, 32, 64'h0, v);
    chk("done_bit", v[0], 1'b1);
    host.scan(4, 8'h03, 10, {54'h0, cfg_ctrl_pkg::IR_RECONFIG_PULSE}, v);
    wait_n(4);
    chk("pulse", {done_oe, dut.o_user_mode}, 2'b10);
    $display("test jtag done");
    test_done();
  end
endmodule
